/* File: bench/omd_fetch_model.sv */
// instruction fetch stream model offering op and operand bytes
`timescale 1ns/1ps
module omd_fetch_model #(
  parameter int PC_W = 16
) (
  // clock
  input  wire logic          clk_sys,
  // op byte offer
  output logic               opValid,
  output logic [7:0]         opByte,
  output logic [PC_W-1:0]    opPc,
  output omd_pkg::omd_mode_t srcMode,
  output omd_pkg::omd_mode_t dstMode,
  output logic [1:0]         operandCount,
  output logic [3:0]         idxSel,
  input  wire logic          opReady,
  // operand byte offer
  output logic               byteValid,
  output logic [7:0]         byteData,
  input  wire logic          byteReady
);
  // idle lines at time zero
  initial begin
    opValid = 1'b0;
    opByte = 8'h5A;
    opPc = '0;
    srcMode = omd_pkg::MODE_NONE;
    dstMode = omd_pkg::MODE_NONE;
    operandCount = 2'h0;
    idxSel = 4'h0;
    byteValid = 1'b0;
    byteData = 8'hA5;
  end

  // one instruction: op byte, then operandCount operand bytes (none for 0 or 3), source before destination
  task automatic send(input logic [7:0] op, input logic [PC_W-1:0] pc,
    input omd_pkg::omd_mode_t m, input logic [1:0] cnt,
    input logic [3:0] idx, input logic [7:0] b0, b1, input int gap);
    logic [7:0] bytes [2];
    int n;
    bytes[0] = b0;
    bytes[1] = b1;
    n = (cnt == 2'h3) ? 0 : int'(cnt);
    @(posedge clk_sys);
    opValid <= 1'b1;
    opByte <= op;
    opPc <= pc;
    srcMode <= m;
    dstMode <= m;
    operandCount <= cnt;
    idxSel <= idx;
    do @(negedge clk_sys); while (opReady !== 1'b1);
    @(posedge clk_sys);
    opValid <= 1'b0;
    opByte <= ~op; // released line shows no stale value
    for (int i = 0; i < n; i++) begin
      if (gap > 0) begin
        byteValid <= 1'b0;
        byteData <= ~byteData;
        repeat (gap) @(posedge clk_sys);
      end
      byteValid <= 1'b1;
      byteData <= bytes[i];
      do @(negedge clk_sys); while (byteReady !== 1'b1);
      @(posedge clk_sys);
    end
    if (n > 0) begin
      byteValid <= 1'b0;
      byteData <= ~byteData;
    end
  endtask : send
endmodule : omd_fetch_model

/* File: bench/tb_omd_decode.sv */
// self-checking bench for the operand mode decoder
`timescale 1ns/1ps
module tb_omd_decode;
  logic clk_sys, arst_n, opValid, opReady, byteValid, byteReady, opndValid;
  logic opndIsDst, opndIndirect, opndPairOdd, condTrue, cfgWrEn, cfgRdHit;
  logic [7:0] opByte, byteData, opndAddr, opndData, cfgWrAddr, cfgWrData;
  logic [7:0] cfgRdAddr, cfgRdData, intMaskCtrl, statusFlags, workBankPointer;
  logic [15:0] opPc, relTarget;
  logic [3:0] idxSel, condField;
  logic [1:0] operandCount;
  omd_pkg::omd_mode_t srcMode, dstMode, opndMode;
  logic [7:0] gotAddr [2], gotData [2], nGot;
  logic gotDst [2], gotInd [2], gotOdd [2];
  int badCount = 0, nCompared = 0, cyc = 0;
  logic [7:0] fl;

  omd_decode dut (.clk_sys(clk_sys), .arst_n(arst_n), .opValid(opValid),
    .opByte(opByte), .opPc(opPc), .srcMode(srcMode), .dstMode(dstMode),
    .operandCount(operandCount), .idxSel(idxSel), .opReady(opReady),
    .byteValid(byteValid), .byteData(byteData), .byteReady(byteReady),
    .opndValid(opndValid), .opndIsDst(opndIsDst), .opndMode(opndMode),
    .opndAddr(opndAddr), .opndData(opndData), .opndIndirect(opndIndirect),
    .opndPairOdd(opndPairOdd), .relTarget(relTarget),
    .condField(condField), .condTrue(condTrue), .cfgWrEn(cfgWrEn),
    .cfgWrAddr(cfgWrAddr), .cfgWrData(cfgWrData), .cfgRdAddr(cfgRdAddr),
    .cfgRdData(cfgRdData), .cfgRdHit(cfgRdHit), .intMaskCtrl(intMaskCtrl),
    .statusFlags(statusFlags), .workBankPointer(workBankPointer));
  omd_fetch_model fetch (.clk_sys(clk_sys), .opValid(opValid),
    .opByte(opByte), .opPc(opPc), .srcMode(srcMode), .dstMode(dstMode),
    .operandCount(operandCount), .idxSel(idxSel), .opReady(opReady),
    .byteValid(byteValid), .byteData(byteData), .byteReady(byteReady));

  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // capture each resolved operand pulse
  always @(posedge clk_sys) begin
    if (opndValid === 1'b1 && nGot < 8'h02) begin
      gotDst[nGot[0]] <= opndIsDst;
      gotAddr[nGot[0]] <= opndAddr;
      gotData[nGot[0]] <= opndData;
      gotInd[nGot[0]] <= opndIndirect;
      gotOdd[nGot[0]] <= opndPairOdd;
      nGot <= nGot + 8'h01;
    end
  end

  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      badCount++;
      results();
    end
  end

  task automatic chk1(input string nm, input logic e, g);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk1

  task automatic chk8(input string nm, input logic [7:0] e, g);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk16(input string nm, input logic [15:0] e, g);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16

  task automatic chkOp(input int i, input logic d, input logic [7:0] a, dt,
    input logic ind, odd);
    chk1("opndIsDst", d, gotDst[i]);
    chk8("opndAddr", a, gotAddr[i]);
    chk8("opndData", dt, gotData[i]);
    chk1("opndIndirect", ind, gotInd[i]);
    chk1("opndPairOdd", odd, gotOdd[i]);
  endtask : chkOp

  task automatic cfgWrite(input logic [7:0] a, d);
    @(posedge clk_sys);
    cfgWrEn <= 1'b1;
    cfgWrAddr <= a;
    cfgWrData <= d;
    @(posedge clk_sys);
    cfgWrEn <= 1'b0;
  endtask : cfgWrite

  task automatic cfgRead(input logic [7:0] a, d, input logic hit);
    @(posedge clk_sys);
    cfgRdAddr <= a;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk8("cfgRdData", d, cfgRdData);
    chk1("cfgRdHit", hit, cfgRdHit);
  endtask : cfgRead

  task automatic instr(input logic [7:0] op, input logic [15:0] pc,
    input omd_pkg::omd_mode_t m, input logic [1:0] cnt,
    input logic [3:0] idx, input logic [7:0] b0, b1, input int gap);
    nGot = 8'h00;
    fetch.send(op, pc, m, cnt, idx, b0, b1, gap);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk8("operands", 8'((cnt == 2'h3) ? 2'h0 : cnt), nGot);
  endtask : instr

  // expected condition result from the flag table
  function automatic logic condExp(input logic [3:0] c, input logic [7:0] f);
    logic r, fc, fz, fs, fv;
    fc = f[omd_pkg::FLAG_C];
    fz = f[omd_pkg::FLAG_Z];
    fs = f[omd_pkg::FLAG_S];
    fv = f[omd_pkg::FLAG_V];
    case (c[2:0])
      3'h0: r = 1'b0;
      3'h1: r = fs ^ fv;
      3'h2: r = fz | (fs ^ fv);
      3'h3: r = fc | fz;
      3'h4: r = fv;
      3'h5: r = fs;
      3'h6: r = fz;
      default: r = fc;
    endcase
    return r ^ c[3];
  endfunction : condExp

  task automatic results();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // main sequence
  initial begin
    arst_n = 1'b0;
    cfgWrEn = 1'b0;
    cfgWrAddr = 8'h00;
    cfgWrData = 8'h00;
    cfgRdAddr = 8'h00;
    nGot = 8'h00;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    chk1("opReady", 1'b1, opReady);
    chk1("byteReady", 1'b0, byteReady);
    for (int i = 0; i < 3; i++) begin
      cfgRead(8'hFB + 8'(i), 8'h00, 1'b1);
    end
    cfgWrite(8'hFB, 8'h5A);
    cfgWrite(8'hFC, 8'hA0);
    cfgWrite(8'hFD, 8'hF0);
    cfgWrite(8'h10, 8'h77);
    cfgWrite(8'hED, 8'h30);
    cfgRead(8'hFB, 8'h5A, 1'b1);
    cfgRead(8'hFC, 8'hA0, 1'b1);
    cfgRead(8'hFD, 8'h30, 1'b1);
    cfgRead(8'h10, 8'h00, 1'b0);
    chk8("intMaskCtrl", 8'h5A, intMaskCtrl);
    chk8("workBankPointer", 8'h30, workBankPointer);
    instr(8'h04, 16'h0100, omd_pkg::MODE_REG, 2'h2, 4'h0, 8'h08, 8'h43, 0);
    chk8("operands", 8'h02, nGot);
    chkOp(0, 1'b0, 8'h08, 8'h08, 1'b0, 1'b0);
    chkOp(1, 1'b1, 8'h43, 8'h43, 1'b0, 1'b0);
    instr(8'h20, 16'h0103, omd_pkg::MODE_REG, 2'h1, 4'h0, 8'hE5, 8'h00, 2);
    chkOp(0, 1'b1, 8'h35, 8'hE5, 1'b0, 1'b0);
    instr(8'h80, 16'h0105, omd_pkg::MODE_PAIR, 2'h2, 4'h0, 8'hFE, 8'h13, 1);
    chkOp(0, 1'b0, 8'hFE, 8'hFE, 1'b0, 1'b0);
    chkOp(1, 1'b1, 8'h13, 8'h13, 1'b0, 1'b1);
    instr(8'hD4, 16'h0108, omd_pkg::MODE_INDPAIR, 2'h1, 4'h0, 8'h22, 8'h0, 0);
    chkOp(0, 1'b1, 8'h22, 8'h22, 1'b1, 1'b0);
    instr(8'h8B, 16'h1000, omd_pkg::MODE_REL, 2'h1, 4'h0, 8'h80, 8'h00, 0);
    chk16("relTarget", 16'h0F82, relTarget);
    instr(8'h8B, 16'h1000, omd_pkg::MODE_REL, 2'h1, 4'h0, 8'h7F, 8'h00, 0);
    chk16("relTarget", 16'h1081, relTarget);
    instr(8'h0C, 16'h1002, omd_pkg::MODE_IMM, 2'h1, 4'h0, 8'hFF, 8'h00, 0);
    chkOp(0, 1'b1, 8'h00, 8'hFF, 1'b0, 1'b0);
    chk16("relTarget", 16'h1081, relTarget);
    instr(8'hD6, 16'h1004, omd_pkg::MODE_DIRECT, 2'h1, 4'h0, 8'hA5, 8'h0, 0);
    chk8("opndData", 8'hA5, gotData[0]);
    chkOp(0, 1'b1, 8'hA5, 8'hA5, 1'b0, 1'b0);
    instr(8'hC7, 16'h1006, omd_pkg::MODE_INDEX, 2'h1, 4'hF, 8'h80, 8'h0, 0);
    chkOp(0, 1'b1, 8'h3F, 8'h80, 1'b0, 1'b0);
    instr(8'hE3, 16'h1008, omd_pkg::MODE_WORK, 2'h2, 4'h0, 8'h07, 8'h0C, 0);
    chkOp(0, 1'b0, 8'h37, 8'h07, 1'b0, 1'b0);
    chkOp(1, 1'b1, 8'h3C, 8'h0C, 1'b0, 1'b0);
    chk8("opndMode", 8'(omd_pkg::MODE_WORK), 8'(opndMode));
    instr(8'h21, 16'h100B, omd_pkg::MODE_IND, 2'h1, 4'h0, 8'hE9, 8'h00, 1);
    chkOp(0, 1'b1, 8'h39, 8'hE9, 1'b1, 1'b0);
    instr(8'hE3, 16'h100D, omd_pkg::MODE_WIND, 2'h1, 4'h0, 8'h54, 8'h00, 0);
    chkOp(0, 1'b1, 8'h34, 8'h54, 1'b1, 1'b0);
    chk8("opndMode", 8'(omd_pkg::MODE_WIND), 8'(opndMode));
    for (int k = 0; k < 2; k++) begin
      fl = (k == 0) ? 8'hA0 : 8'h50;
      cfgWrite(8'hFC, fl);
      @(negedge clk_sys);
      chk8("statusFlags", fl, statusFlags);
      for (int c = 0; c < 16; c++) begin
        instr({4'(c), 4'hD}, 16'h2000, omd_pkg::MODE_NONE, 2'h0, 4'h0,
          8'h00, 8'h00, 0);
        chk8("condField", {4'h0, 4'(c)}, {4'h0, condField});
        chk1("condTrue", condExp(4'(c), fl), condTrue);
      end
    end
    results();
  end
endmodule : tb_omd_decode

/* File: hdl/omd_cond_eval.sv */
// condition field test against the status flags
`timescale 1ns/1ps
module omd_cond_eval (
  // condition and flags
  input  wire logic [3:0] condField,
  input  wire logic [7:0] statusFlags,
  // result
  output logic            condTrue
);

  logic       baseTest;
  logic       sxv;

  // eight base tests, bit 3 of the field negates them
  always_comb begin
    sxv = statusFlags[omd_pkg::FLAG_S] ^ statusFlags[omd_pkg::FLAG_V];
    case (condField[2:0])
      omd_pkg::COND_FALSE: baseTest = 1'b0;
      omd_pkg::COND_LT:    baseTest = sxv;
      omd_pkg::COND_LE:    baseTest = statusFlags[omd_pkg::FLAG_Z] | sxv;
      omd_pkg::COND_ULE:   baseTest = statusFlags[omd_pkg::FLAG_C]
                                    | statusFlags[omd_pkg::FLAG_Z];
      omd_pkg::COND_OV:    baseTest = statusFlags[omd_pkg::FLAG_V];
      omd_pkg::COND_MI:    baseTest = statusFlags[omd_pkg::FLAG_S];
      omd_pkg::COND_ZERO:  baseTest = statusFlags[omd_pkg::FLAG_Z];
      omd_pkg::COND_CARRY: baseTest = statusFlags[omd_pkg::FLAG_C];
      default:             baseTest = 1'b0;
    endcase
    condTrue = baseTest ^ condField[omd_pkg::COND_NEG_BIT];
    // always-true code must pass whatever the flags hold, checked in the
    // same process so a half-updated field cannot trip it
    condAlways_a: assert (condField != 4'h8 || condTrue)
      else $error("condition 8 did not test true");
  end

endmodule : omd_cond_eval

/* File: hdl/omd_decode.sv */
// operand addressing-mode decoder with the control registers
`timescale 1ns/1ps
module omd_decode #(
  parameter int PC_W = 16
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // op byte from fetch
  input  wire logic              opValid,
  input  wire logic [7:0]        opByte,
  input  wire logic [PC_W-1:0]   opPc,
  input  wire omd_pkg::omd_mode_t srcMode,
  input  wire omd_pkg::omd_mode_t dstMode,
  input  wire logic [1:0]        operandCount,
  input  wire logic [3:0]        idxSel,
  output logic                   opReady,
  // operand bytes from fetch
  input  wire logic              byteValid,
  input  wire logic [7:0]        byteData,
  output logic                   byteReady,
  // resolved operand
  output logic                   opndValid,
  output logic                   opndIsDst,
  output omd_pkg::omd_mode_t     opndMode,
  output logic [7:0]             opndAddr,
  output logic [7:0]             opndData,
  output logic                   opndIndirect,
  output logic                   opndPairOdd,
  output logic [PC_W-1:0]        relTarget,
  // condition of the current instruction
  output logic [3:0]             condField,
  output logic                   condTrue,
  // control register access from execute
  input  wire logic              cfgWrEn,
  input  wire logic [7:0]        cfgWrAddr,
  input  wire logic [7:0]        cfgWrData,
  input  wire logic [7:0]        cfgRdAddr,
  output logic [7:0]             cfgRdData,
  output logic                   cfgRdHit,
  output logic [7:0]             intMaskCtrl,
  output logic [7:0]             statusFlags,
  output logic [7:0]             workBankPointer
);

  // working register address inside the current bank
  function automatic logic [7:0] workAddr(input logic [7:0] bank,
                                          input logic [3:0] sel);
    workAddr = {bank[7:4], sel};
  endfunction : workAddr

  // full register address, escape nibble selects a working register
  function automatic logic [7:0] regAddr(input logic [7:0] bank,
                                         input logic [7:0] opnd);
    if (opnd[7:4] == omd_pkg::WORK_ESC) begin
      regAddr = workAddr(bank, opnd[3:0]);
    end else begin
      regAddr = opnd;
    end
  endfunction : regAddr

  omd_pkg::omd_state_t stateQ, stateD;
  omd_pkg::omd_mode_t  srcModeQ, srcModeD, dstModeQ, dstModeD, curMode;
  logic [3:0]          idxSelQ, idxSelD;
  logic [PC_W-1:0]     nextPcQ, nextPcD;
  logic                opndValidQ, opndValidD, opndIsDstQ, opndIsDstD;
  omd_pkg::omd_mode_t  opndModeQ, opndModeD;
  logic [7:0]          opndAddrQ, opndAddrD, opndDataQ, opndDataD;
  logic                opndIndQ, opndIndD, opndOddQ, opndOddD;
  logic [PC_W-1:0]     relTargetQ, relTargetD, relOffset;
  logic [3:0]          condFieldQ, condFieldD;
  logic                condTrueQ, condTrueD, condNow;
  logic [7:0]          intMaskQ, intMaskD, flagsQ, flagsD, bankPtrQ, bankPtrD;
  logic [7:0]          rdDataQ, rdDataD, wrFull, rdFull;
  logic                rdHitQ, rdHitD;

  // condition test on the incoming op byte
  omd_cond_eval u_cond (
    .condField   (opByte[omd_pkg::COND_MSB:omd_pkg::COND_LSB]),
    .statusFlags (flagsQ),
    .condTrue    (condNow)
  );

  // handshakes: one instruction at a time
  assign opReady   = (stateQ == omd_pkg::ST_IDLE);
  assign byteReady = (stateQ != omd_pkg::ST_IDLE);
  assign curMode   = (stateQ == omd_pkg::ST_SRC) ? srcModeQ : dstModeQ;
  assign relOffset = {{(PC_W-8){byteData[7]}}, byteData};

  // sequence and operand resolution
  always_comb begin
    stateD     = stateQ;
    srcModeD   = srcModeQ;
    dstModeD   = dstModeQ;
    idxSelD    = idxSelQ;
    nextPcD    = nextPcQ;
    condFieldD = condFieldQ;
    condTrueD  = condTrueQ;
    opndValidD = 1'b0;
    opndIsDstD = opndIsDstQ;
    opndModeD  = opndModeQ;
    opndAddrD  = opndAddrQ;
    opndDataD  = opndDataQ;
    opndIndD   = opndIndQ;
    opndOddD   = opndOddQ;
    relTargetD = relTargetQ;
    case (stateQ)
      omd_pkg::ST_IDLE: begin
        if (opValid) begin
          srcModeD   = srcMode;
          dstModeD   = dstMode;
          idxSelD    = idxSel;
          nextPcD    = opPc + PC_W'(operandCount) + PC_W'(1);
          condFieldD = opByte[omd_pkg::COND_MSB:omd_pkg::COND_LSB];
          condTrueD  = condNow;
          if (operandCount == 2'd2) begin
            stateD = omd_pkg::ST_SRC;
          end else if (operandCount == 2'd1) begin
            stateD = omd_pkg::ST_DST;
          end
        end
      end
      omd_pkg::ST_SRC, omd_pkg::ST_DST: begin
        if (byteValid) begin
          opndValidD = 1'b1;
          opndIsDstD = (stateQ == omd_pkg::ST_DST);
          opndModeD  = curMode;
          opndDataD  = byteData;
          opndIndD   = (curMode == omd_pkg::MODE_WIND)
                     | (curMode == omd_pkg::MODE_IND)
                     | (curMode == omd_pkg::MODE_INDPAIR);
          opndOddD   = ((curMode == omd_pkg::MODE_PAIR)
                     | (curMode == omd_pkg::MODE_INDPAIR))
                     & byteData[0];
          case (curMode)
            omd_pkg::MODE_WORK, omd_pkg::MODE_WIND:
              opndAddrD = workAddr(bankPtrQ, byteData[3:0]);
            omd_pkg::MODE_REG, omd_pkg::MODE_PAIR, omd_pkg::MODE_IND,
            omd_pkg::MODE_INDPAIR:
              opndAddrD = regAddr(bankPtrQ, byteData);
            omd_pkg::MODE_INDEX:
              opndAddrD = workAddr(bankPtrQ, idxSelQ);
            omd_pkg::MODE_DIRECT:
              opndAddrD = byteData;
            default:
              opndAddrD = 8'h00;
          endcase
          if (curMode == omd_pkg::MODE_REL) begin
            relTargetD = nextPcQ + relOffset;
          end
          stateD = (stateQ == omd_pkg::ST_SRC) ? omd_pkg::ST_DST
                                               : omd_pkg::ST_IDLE;
        end
      end
      default: stateD = omd_pkg::ST_IDLE;
    endcase
  end

  // sequence registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stateQ     <= omd_pkg::ST_IDLE;
      srcModeQ   <= omd_pkg::MODE_NONE;
      dstModeQ   <= omd_pkg::MODE_NONE;
      idxSelQ    <= 4'h0;
      nextPcQ    <= '0;
      condFieldQ <= 4'h0;
      condTrueQ  <= 1'b0;
      opndValidQ <= 1'b0;
      opndIsDstQ <= 1'b0;
      opndModeQ  <= omd_pkg::MODE_NONE;
      opndAddrQ  <= 8'h00;
      opndDataQ  <= 8'h00;
      opndIndQ   <= 1'b0;
      opndOddQ   <= 1'b0;
      relTargetQ <= '0;
    end else begin
      stateQ     <= stateD;
      srcModeQ   <= srcModeD;
      dstModeQ   <= dstModeD;
      idxSelQ    <= idxSelD;
      nextPcQ    <= nextPcD;
      condFieldQ <= condFieldD;
      condTrueQ  <= condTrueD;
      opndValidQ <= opndValidD;
      opndIsDstQ <= opndIsDstD;
      opndModeQ  <= opndModeD;
      opndAddrQ  <= opndAddrD;
      opndDataQ  <= opndDataD;
      opndIndQ   <= opndIndD;
      opndOddQ   <= opndOddD;
      relTargetQ <= relTargetD;
    end
  end

  // control registers written and read through ordinary addresses
  always_comb begin
    wrFull   = regAddr(bankPtrQ, cfgWrAddr);
    rdFull   = regAddr(bankPtrQ, cfgRdAddr);
    intMaskD = intMaskQ;
    flagsD   = flagsQ;
    bankPtrD = bankPtrQ;
    if (cfgWrEn) begin
      case (wrFull)
        omd_pkg::INT_MASK_ADDR:   intMaskD = cfgWrData;
        omd_pkg::STAT_FLAGS_ADDR: flagsD   = cfgWrData;
        omd_pkg::BANK_PTR_ADDR:   bankPtrD = cfgWrData;
        default: ;
      endcase
    end
    rdHitD = 1'b1;
    case (rdFull)
      omd_pkg::INT_MASK_ADDR:   rdDataD = intMaskQ;
      omd_pkg::STAT_FLAGS_ADDR: rdDataD = flagsQ;
      omd_pkg::BANK_PTR_ADDR:   rdDataD = bankPtrQ;
      default: begin
        rdDataD = 8'h00;
        rdHitD  = 1'b0;
      end
    endcase
  end

  // control register storage
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      intMaskQ <= omd_pkg::INT_MASK_RST;
      flagsQ   <= omd_pkg::STAT_FLAGS_RST;
      bankPtrQ <= omd_pkg::BANK_PTR_RST;
      rdDataQ  <= 8'h00;
      rdHitQ   <= 1'b0;
    end else begin
      intMaskQ <= intMaskD;
      flagsQ   <= flagsD;
      bankPtrQ <= bankPtrD;
      rdDataQ  <= rdDataD;
      rdHitQ   <= rdHitD;
    end
  end

  // outputs
  assign opndValid       = opndValidQ;
  assign opndIsDst       = opndIsDstQ;
  assign opndMode        = opndModeQ;
  assign opndAddr        = opndAddrQ;
  assign opndData        = opndDataQ;
  assign opndIndirect    = opndIndQ;
  assign opndPairOdd     = opndOddQ;
  assign relTarget       = relTargetQ;
  assign condField       = condFieldQ;
  assign condTrue        = condTrueQ;
  assign cfgRdData       = rdDataQ;
  assign cfgRdHit        = rdHitQ;
  assign intMaskCtrl     = intMaskQ;
  assign statusFlags     = flagsQ;
  assign workBankPointer = bankPtrQ;

  // checks on the decoded results and the bank pointer write
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  workResolve_a: assert property (
    opndValid && opndMode == omd_pkg::MODE_WORK |->
      opndAddr == {$past(bankPtrQ[7:4]), $past(byteData[3:0])})
    else $error("working register not resolved in bank");
  pairOdd_a: assert property (
    opndValid && opndMode == omd_pkg::MODE_PAIR |->
      opndPairOdd == opndData[0])
    else $error("odd pair flag wrong");
  indirect_a: assert property (
    opndValid && opndMode == omd_pkg::MODE_INDPAIR |->
      opndIndirect && opndAddr == regAddr($past(bankPtrQ), opndData))
    else $error("indirect pair not marked");
  relTarget_a: assert property (
    byteReady && byteValid && curMode == omd_pkg::MODE_REL |=>
      relTarget == $past(nextPcQ) + $past(relOffset))
    else $error("relative target wrong");
  indexSel_a: assert property (
    opndValid && opndMode == omd_pkg::MODE_INDEX |->
      opndAddr[3:0] == idxSelQ && opndData == $past(byteData))
    else $error("indexed operand wrong");
  literal_a: assert property (
    opndValid && opndMode == omd_pkg::MODE_IMM |->
      opndData == $past(byteData))
    else $error("immediate literal lost");
  direct_a: assert property (
    opndValid && opndMode == omd_pkg::MODE_DIRECT |-> opndAddr == opndData)
    else $error("direct target wrong");
  ctrlWrite_a: assert property (
    cfgWrEn && regAddr(bankPtrQ, cfgWrAddr) == omd_pkg::BANK_PTR_ADDR |=>
      workBankPointer == $past(cfgWrData))
    else $error("bank pointer write lost");
  condLatch_a: assert property (
    opValid && opReady |=> condField == $past(opByte[7:4])
      && condTrue == $past(condNow))
    else $error("condition field not latched");
  srcFirst_a: assert property (
    opValid && opReady && operandCount == 2'd2 ##1 byteValid |=>
      opndValid && !opndIsDst)
    else $error("source byte not taken first");

endmodule : omd_decode

/* File: pkg/omd_pkg.sv */
// constants, modes and states shared by the operand mode decoder
package omd_pkg;

  // control register locations in the register file
  localparam logic [7:0] INT_MASK_ADDR   = 8'hFB;
  localparam logic [7:0] STAT_FLAGS_ADDR = 8'hFC;
  localparam logic [7:0] BANK_PTR_ADDR   = 8'hFD;

  // reset values of the control registers
  localparam logic [7:0] INT_MASK_RST    = 8'h00;
  localparam logic [7:0] STAT_FLAGS_RST  = 8'h00;
  localparam logic [7:0] BANK_PTR_RST    = 8'h00;

  // high nibble that marks an 8-bit operand as a working register
  localparam logic [3:0] WORK_ESC        = 4'hE;

  // flag bit positions in the status flags register
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;

  // condition field position in the op byte and its negate bit
  localparam int COND_LSB     = 4;
  localparam int COND_MSB     = 7;
  localparam int COND_NEG_BIT = 3;

  // base condition tests, bit 3 of the field inverts them
  localparam logic [2:0] COND_FALSE = 3'h0;
  localparam logic [2:0] COND_LT    = 3'h1;
  localparam logic [2:0] COND_LE    = 3'h2;
  localparam logic [2:0] COND_ULE   = 3'h3;
  localparam logic [2:0] COND_OV    = 3'h4;
  localparam logic [2:0] COND_MI    = 3'h5;
  localparam logic [2:0] COND_ZERO  = 3'h6;
  localparam logic [2:0] COND_CARRY = 3'h7;

  // operand addressing modes
  typedef enum logic [3:0] {
    MODE_NONE, MODE_WORK, MODE_REG, MODE_PAIR, MODE_WIND, MODE_IND,
    MODE_INDPAIR, MODE_INDEX, MODE_DIRECT, MODE_REL, MODE_IMM
  } omd_mode_t;

  // decoder sequence states
  typedef enum logic [1:0] {ST_IDLE, ST_SRC, ST_DST} omd_state_t;

endpackage : omd_pkg
